//--- hw/ascm_pkg.sv
package ascm_pkg;
  localparam int SPEED_W = 16;
  localparam int FEED_W = 32;
  localparam int AUX_W = 16;
  localparam int ERR_W = 10;
  localparam int STATUS_W = 16;
  localparam int STAT_IN_SPEED_BIT = 0;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [FEED_W-1:0] FEED_ZERO = 32'h0000_0000;
  // Error codes
  localparam logic [ERR_W-1:0] ERR_NONE = 10'h000;
  localparam logic [ERR_W-1:0] ERR_CONT_PATH = 10'h204;   // 516
  localparam logic [ERR_W-1:0] ERR_METHOD = 10'h20C;      // 524
  // Operation pattern encodings
  localparam logic [1:0] PAT_COMPLETE = 2'h0;
  localparam logic [1:0] PAT_CONT_POS = 2'h1;
  localparam logic [1:0] PAT_CONT_PATH = 2'h3;
  // Control method encodings for the two speed variants
  localparam logic [5:0] METH_FWD_SPEED = 6'h04;
  localparam logic [5:0] METH_REV_SPEED = 6'h05;
  // Feed value during speed control setting
  localparam logic [1:0] FEED_HOLD = 2'h0;
  localparam logic [1:0] FEED_UPDATE = 2'h1;
  localparam logic [1:0] FEED_CLEAR = 2'h2;
  // Aux code timing setting
  localparam logic AUX_WITH = 1'b0;
  localparam logic AUX_AFTER = 1'b1;
  // Speed ramp step per cycle
  localparam logic [SPEED_W-1:0] RAMP_STEP_DEFAULT = 16'h0001;

  typedef enum logic [1:0] {
    ASCM_IDLE = 2'b00,
    ASCM_RUN = 2'b01,
    ASCM_DECEL = 2'b11
  } ascm_state_e;
endpackage : ascm_pkg

//--- hw/ascm_ramp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ascm_ramp_if;
  logic [ascm_pkg::SPEED_W-1:0] target;
  logic [ascm_pkg::SPEED_W-1:0] step;
  logic clear;
  logic [ascm_pkg::SPEED_W-1:0] speed;
  logic at_zero;
  modport ctrl (output target, output step, output clear, input speed, input at_zero);
  modport ramp (input target, input step, input clear, output speed, output at_zero);
endinterface : ascm_ramp_if
`default_nettype wire

//--- hw/ascm_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module ascm_ramp (
  input wire logic clk,
  input wire logic rst_n,
  ascm_ramp_if.ramp rif
);
  logic [ascm_pkg::SPEED_W-1:0] speed_reg;

  function automatic logic [ascm_pkg::SPEED_W-1:0] approach(
    input logic [ascm_pkg::SPEED_W-1:0] cur,
    input logic [ascm_pkg::SPEED_W-1:0] tgt,
    input logic [ascm_pkg::SPEED_W-1:0] stp
  );
    logic [ascm_pkg::SPEED_W-1:0] r;
    r = tgt;
    if (cur < tgt) begin
      if (tgt - cur > stp) begin
        r = cur + stp;
      end
    end else if (cur - tgt > stp) begin
      r = cur - stp;
    end
    return r;
  endfunction : approach

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_reg <= '0;
    end else if (rif.clear) begin
      speed_reg <= '0;
    end else begin
      speed_reg <= approach(speed_reg, rif.target, rif.step);
    end
  end

  assign rif.speed = speed_reg;
  assign rif.at_zero = (speed_reg == '0);
endmodule : ascm_ramp
`default_nettype wire

//--- hw/ascm_speed_ctrl.sv
// Notes on behaviour
// [RULE_01] Run at commanded speed in data direction, no target, until stop.
// [RULE_02] Two variants: forward-start and reverse-start speed control.
// [RULE_03] Status bit 0 high for whole speed control operation.
// [RULE_04] Continuous positioning or path pattern refused with error 516.
// [RULE_05] Aux code and its on signal only with concurrent timing setting.
// [RULE_06] Stroke limit check skipped when unit is degrees.
// [RULE_07] Infinite length restoration needs feed setting 1, else error 524.
// [RULE_08] Movement amount, arc address and dwell time are ignored.
// [RULE_09] Feed setting: 0 hold, 1 update continuously, 2 clear at start.
// [RULE_10] Stop decelerates with selected time, then status flag drops.
`timescale 1ns/1ns
`default_nettype none
module ascm_speed_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] operation_pattern_field,
  input wire logic [5:0] control_method_field,
  input wire logic [31:0] movement_amount_field,
  input wire logic [31:0] arc_center_field,
  input wire logic [15:0] dwell_time_field,
  input wire logic [ascm_pkg::SPEED_W-1:0] commanded_speed_field,
  input wire logic [ascm_pkg::AUX_W-1:0] aux_code_field,
  input wire logic aux_code_timing_setting,
  input wire logic [1:0] feed_value_during_speed_setting,
  input wire logic unit_is_degree,
  input wire logic abs_infinite_mode,
  input wire logic [ascm_pkg::SPEED_W-1:0] decel_step,
  input wire logic [ascm_pkg::FEED_W-1:0] stroke_upper,
  input wire logic [ascm_pkg::FEED_W-1:0] stroke_lower,
  input wire logic aux_code_done,
  output logic [ascm_pkg::SPEED_W-1:0] speed_cmd,
  output logic dir_reverse,
  output logic [ascm_pkg::STATUS_W-1:0] axis_status_monitor,
  output logic [ascm_pkg::FEED_W-1:0] current_feed_value_monitor,
  output logic [ascm_pkg::ERR_W-1:0] error_code,
  output logic error_pulse,
  output logic stroke_error,
  output logic [ascm_pkg::AUX_W-1:0] aux_code_out,
  output logic aux_code_on
);
  logic rst_sync1_reg;
  logic rst_n;
  ascm_pkg::ascm_state_e state_reg;
  ascm_pkg::ascm_state_e state_next;
  logic dir_reg;
  logic [ascm_pkg::SPEED_W-1:0] tgt_reg;
  logic [ascm_pkg::SPEED_W-1:0] step_reg;
  logic [1:0] feed_mode_reg;
  logic degree_reg;
  logic [ascm_pkg::FEED_W-1:0] feed_reg;
  logic [ascm_pkg::ERR_W-1:0] err_reg;
  logic err_pulse_reg;
  logic stroke_reg;
  logic [ascm_pkg::AUX_W-1:0] aux_reg;
  logic aux_on_reg;
  logic start_ok;
  logic is_speed_meth;
  logic pat_bad;
  logic abs_bad;
  logic [ascm_pkg::FEED_W-1:0] feed_step;
  logic [ascm_pkg::FEED_W-1:0] feed_new;

  ascm_ramp_if rif ();

  // Async assert, synchronous release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  // Movement amount, arc and dwell are never read here
  assign is_speed_meth = (control_method_field == ascm_pkg::METH_FWD_SPEED) ||
                         (control_method_field == ascm_pkg::METH_REV_SPEED);  // see [RULE_08]
  assign pat_bad = (operation_pattern_field != ascm_pkg::PAT_COMPLETE);  // see [RULE_04]
  assign abs_bad = abs_infinite_mode &&
                   (feed_value_during_speed_setting != ascm_pkg::FEED_UPDATE);  // see [RULE_07]
  assign start_ok = start && is_speed_meth && !pat_bad && !abs_bad &&
                    (state_reg == ascm_pkg::ASCM_IDLE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ascm_pkg::ASCM_IDLE: begin
        if (start_ok) begin
          state_next = ascm_pkg::ASCM_RUN;
        end
      end
      ascm_pkg::ASCM_RUN: begin
        if (stop || stroke_reg) begin
          state_next = ascm_pkg::ASCM_DECEL;  // see [RULE_01]
        end
      end
      ascm_pkg::ASCM_DECEL: begin
        if (rif.at_zero) begin
          state_next = ascm_pkg::ASCM_IDLE;  // see [RULE_10]
        end
      end
      default: state_next = ascm_pkg::ASCM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ascm_pkg::ASCM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latched start data; speed held for the whole run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= 1'b0;
      tgt_reg <= '0;
      step_reg <= ascm_pkg::RAMP_STEP_DEFAULT;
      feed_mode_reg <= ascm_pkg::FEED_HOLD;
      degree_reg <= 1'b0;
    end else if (start_ok) begin
      dir_reg <= (control_method_field == ascm_pkg::METH_REV_SPEED);  // see [RULE_02]
      tgt_reg <= commanded_speed_field;  // see [RULE_01]
      step_reg <= (decel_step == '0) ? ascm_pkg::RAMP_STEP_DEFAULT : decel_step;
      feed_mode_reg <= feed_value_during_speed_setting;
      degree_reg <= unit_is_degree;
    end
  end

  assign rif.target = (state_reg == ascm_pkg::ASCM_RUN) ? tgt_reg : '0;
  assign rif.step = step_reg;  // see [RULE_10]
  // Hold the ramp at rest while idle so no residue carries into a new run
  assign rif.clear = (state_reg == ascm_pkg::ASCM_IDLE);

  ascm_ramp u_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  // Feed moves by current speed each cycle in the run direction
  assign feed_step = {{(ascm_pkg::FEED_W-ascm_pkg::SPEED_W){1'b0}}, rif.speed};
  assign feed_new = dir_reg ? (feed_reg - feed_step) : (feed_reg + feed_step);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feed_reg <= ascm_pkg::FEED_ZERO;
    end else if (start_ok && feed_value_during_speed_setting == ascm_pkg::FEED_CLEAR) begin
      feed_reg <= ascm_pkg::FEED_ZERO;  // see [RULE_09]
    end else if (state_reg != ascm_pkg::ASCM_IDLE && feed_mode_reg == ascm_pkg::FEED_UPDATE) begin
      feed_reg <= feed_new;  // see [RULE_09]
    end
  end

  // Stroke check only when feed tracks motion; never in degrees
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stroke_reg <= 1'b0;
    end else if (start_ok) begin
      stroke_reg <= 1'b0;
    end else if (state_reg == ascm_pkg::ASCM_RUN && !degree_reg &&
                 feed_mode_reg == ascm_pkg::FEED_UPDATE) begin  // see [RULE_06]
      stroke_reg <= ($signed(feed_reg) > $signed(stroke_upper)) ||
                    ($signed(feed_reg) < $signed(stroke_lower));
    end
  end

  // Start refusal codes; pattern error takes priority
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= ascm_pkg::ERR_NONE;
      err_pulse_reg <= 1'b0;
    end else begin
      err_pulse_reg <= 1'b0;
      if (start && is_speed_meth && state_reg == ascm_pkg::ASCM_IDLE) begin
        if (pat_bad) begin
          err_reg <= ascm_pkg::ERR_CONT_PATH;  // see [RULE_04]
          err_pulse_reg <= 1'b1;
        end else if (abs_bad) begin
          err_reg <= ascm_pkg::ERR_METHOD;  // see [RULE_07]
          err_pulse_reg <= 1'b1;
        end
      end
    end
  end

  // Aux code set wins over done in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= '0;
      aux_on_reg <= 1'b0;
    end else if (start_ok && aux_code_timing_setting == ascm_pkg::AUX_WITH) begin
      aux_reg <= aux_code_field;  // see [RULE_05]
      aux_on_reg <= 1'b1;
    end else if (aux_code_done) begin
      aux_on_reg <= 1'b0;
    end
  end

  always_comb begin
    axis_status_monitor = ascm_pkg::STATUS_RESET;
    axis_status_monitor[ascm_pkg::STAT_IN_SPEED_BIT] =
      (state_reg != ascm_pkg::ASCM_IDLE);  // see [RULE_03]
  end

  assign speed_cmd = rif.speed;
  assign dir_reverse = dir_reg;
  assign current_feed_value_monitor = feed_reg;
  assign error_code = err_reg;
  assign error_pulse = err_pulse_reg;
  assign stroke_error = stroke_reg;
  assign aux_code_out = aux_reg;
  assign aux_code_on = aux_on_reg;
endmodule : ascm_speed_ctrl
`default_nettype wire

//--- dv/ascm_servo_model.sv
`timescale 1ns/1ns
`default_nettype none
module ascm_servo_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] speed_cmd,
  input wire logic dir_reverse,
  output logic signed [31:0] pos_reg
);
  // Drive integrates commanded speed into a signed shaft position
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pos_reg <= '0;
    else if (dir_reverse) pos_reg <= pos_reg - 32'(speed_cmd);
    else pos_reg <= pos_reg + 32'(speed_cmd);
  end
endmodule : ascm_servo_model
`default_nettype wire

//--- dv/ascm_speed_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ascm_speed_ctrl_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] operation_pattern_field,
  input wire logic [5:0] control_method_field,
  input wire logic aux_code_timing_setting,
  input wire logic [1:0] feed_value_during_speed_setting,
  input wire logic unit_is_degree,
  input wire logic abs_infinite_mode,
  input wire logic [15:0] speed_cmd,
  input wire logic dir_reverse,
  input wire logic [15:0] axis_status_monitor,
  input wire logic [31:0] current_feed_value_monitor,
  input wire logic [9:0] error_code,
  input wire logic error_pulse,
  input wire logic stroke_error,
  input wire logic aux_code_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic on = axis_status_monitor[0];
  wire logic ok = start && !on && control_method_field[5:1] == 5'h02;
  wire logic pat_ok = operation_pattern_field == ascm_pkg::PAT_COMPLETE;
  wire logic upd = feed_value_during_speed_setting == ascm_pkg::FEED_UPDATE;
  wire logic [31:0] fv = current_feed_value_monitor;
  a_start_runs: assert property (ok && pat_ok
    && !(abs_infinite_mode && !upd) |=> on) else $error("start not taken");
  a_pattern_refused: assert property (ok && !pat_ok |=> error_pulse && !on
    && error_code == ascm_pkg::ERR_CONT_PATH) else $error("pattern not refused");
  a_infinite_refused: assert property (ok && pat_ok && abs_infinite_mode
    && !upd |=> error_pulse && !on && error_code == ascm_pkg::ERR_METHOD) else $error("no 524");
  a_dir_method: assert property ($rose(on) |-> dir_reverse ==
    ($past(control_method_field) == ascm_pkg::METH_REV_SPEED)) else $error("bad direction");
  a_aux_with: assert property ($rose(on) && !$past(aux_code_timing_setting)
    |-> ##[0:1] aux_code_on) else $error("aux on missing");
  a_aux_after: assert property (on && aux_code_timing_setting
    |-> !aux_code_on) else $error("aux on in after mode");
  a_feed_held: assert property (on && $past(on, 2) && !upd
    |-> $stable(fv)) else $error("feed moved");
  a_feed_moves: assert property (on && upd && speed_cmd != 0
    |-> ##[1:2] $changed(fv)) else $error("feed frozen");
  a_stop_ends: assert property (on && stop |-> ##[1:200] !on)
    else $error("run not ended");
  a_decel_falls: assert property (on && stop && $past(stop, 2)
    |-> speed_cmd <= $past(speed_cmd)) else $error("speed rose in stop");
  a_status_spare: assert property (axis_status_monitor[15:1] == 15'h0000)
    else $error("spare status set");
  a_degree_skip: assert property ($rose(stroke_error)
    |-> !$past(unit_is_degree)) else $error("stroke check in degrees");
  c_reverse: cover property ($rose(on) && dir_reverse);
  c_stroke: cover property ($rose(stroke_error));
  c_refused: cover property (error_pulse);
  c_stopped: cover property ($fell(on));
endmodule : ascm_speed_ctrl_asserts
bind ascm_speed_ctrl ascm_speed_ctrl_asserts u_chk (.clk, .rstn, .start, .stop,
  .operation_pattern_field, .control_method_field, .aux_code_timing_setting,
  .feed_value_during_speed_setting, .unit_is_degree, .abs_infinite_mode, .speed_cmd,
  .dir_reverse, .axis_status_monitor, .current_feed_value_monitor, .error_code,
  .error_pulse, .stroke_error, .aux_code_on);
`default_nettype wire

//--- dv/ascm_speed_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ascm_speed_ctrl_tb_top;
  logic clk = 0, rstn = 0, start = 0, stop = 0, tim = 0, deg = 0, inf = 0, done = 0;
  logic dir, eps, serr, aon;
  logic [1:0] pat = 0, feed = 0;
  logic [5:0] meth = 0;
  logic [15:0] spd = 16'h0010, step = 16'h0004, aux = 16'h000A, st, sp, aout;
  logic [31:0] junk = 32'h1234_5678, fv, f0, p0;
  // Limits start wide open; narrowed only for the stroke scenarios
  logic [31:0] up = 32'h7FFF_FFFF, lo = 32'h8000_0000;
  logic [1:0] pat_list [2] = '{ascm_pkg::PAT_CONT_POS, ascm_pkg::PAT_CONT_PATH};
  logic signed [31:0] pos;
  logic [9:0] ec;
  int errors = 0, num_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  ascm_speed_ctrl dut (.clk, .rstn, .start, .stop, .operation_pattern_field(pat),
    .control_method_field(meth), .movement_amount_field(junk), .arc_center_field(~junk),
    .dwell_time_field(junk[15:0]), .commanded_speed_field(spd), .aux_code_field(aux),
    .aux_code_timing_setting(tim), .feed_value_during_speed_setting(feed),
    .unit_is_degree(deg), .abs_infinite_mode(inf), .decel_step(step),
    .stroke_upper(up), .stroke_lower(lo), .aux_code_done(done),
    .speed_cmd(sp), .dir_reverse(dir), .axis_status_monitor(st),
    .current_feed_value_monitor(fv), .error_code(ec), .error_pulse(eps),
    .stroke_error(serr), .aux_code_out(aout), .aux_code_on(aon));
  ascm_servo_model servo (.clk, .rstn, .speed_cmd(sp), .dir_reverse(dir), .pos_reg(pos));
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic go(input logic [5:0] m, input logic [1:0] p, input logic [1:0] f, input logic t);
    meth = m; pat = p; feed = f; tim = t; f0 = fv; p0 = pos;
    start = 1;
    cyc(1);
    start = 0;
  endtask : go
  task automatic settle;
    repeat (100) if (sp !== spd) cyc(1);
  endtask : settle
  task automatic halt;
    stop = 1; done = 1;
    cyc(1);
    done = 0;
    repeat (300) if (st[0] !== 1'b0) cyc(1);
    chk(st, 0);
    chk(sp, 0);
    stop = 0;
    cyc(2);
  endtask : halt
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1;
    cyc(4);
    chk(st, ascm_pkg::STATUS_RESET);
    go(ascm_pkg::METH_FWD_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_UPDATE, ascm_pkg::AUX_WITH);
    chk(st, 1);
    cyc(1);
    chk(dir, 0);
    chk(aon, 1);
    chk(aout, aux);
    settle();
    chk(sp, spd);
    cyc(10);
    chk(st, 1);
    chk(32'(pos > p0), 1);
    chk(32'(fv != f0), 1);
    halt();
    $display("test forward done");
    // Ignored fields change between runs and must not matter
    junk = 32'h0F0F_F0F0;
    go(ascm_pkg::METH_REV_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_HOLD, ascm_pkg::AUX_AFTER);
    cyc(1);
    chk(dir, 1);
    chk(aon, 0);
    settle();
    chk(sp, spd);
    cyc(5);
    chk(32'(pos < p0), 1);
    chk(fv, f0);
    halt();
    $display("test reverse done");
    go(ascm_pkg::METH_FWD_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_CLEAR, ascm_pkg::AUX_AFTER);
    cyc(2);
    chk(32'(f0 != 0), 1);
    chk(fv, ascm_pkg::FEED_ZERO);
    cyc(8);
    chk(fv, ascm_pkg::FEED_ZERO);
    halt();
    $display("test clear done");
    foreach (pat_list[i]) begin
      go(ascm_pkg::METH_FWD_SPEED, pat_list[i], ascm_pkg::FEED_HOLD, ascm_pkg::AUX_AFTER);
      chk(eps, 1);
      chk(ec, ascm_pkg::ERR_CONT_PATH);
      chk(st, 0);
      cyc(2);
    end
    inf = 1;
    go(ascm_pkg::METH_FWD_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_HOLD, ascm_pkg::AUX_AFTER);
    chk(eps, 1);
    chk(ec, ascm_pkg::ERR_METHOD);
    chk(st, 0);
    cyc(2);
    $display("test refusals done");
    // Narrow limits: feed leaves them at once, only degrees or a feed setting other than 1 may ignore it
    up = 32'h0000_0000;
    lo = 32'h0000_0000;
    deg = 1;
    go(ascm_pkg::METH_FWD_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_UPDATE, ascm_pkg::AUX_AFTER);
    chk(st, 1);
    cyc(30);
    chk(serr, 0);
    chk(st, 1);
    halt();
    deg = 0;
    go(ascm_pkg::METH_FWD_SPEED, ascm_pkg::PAT_COMPLETE,
       ascm_pkg::FEED_UPDATE, ascm_pkg::AUX_AFTER);
    repeat (300) if (st[0] !== 1'b0) cyc(1);
    chk(serr, 1);
    chk(st, 0);
    chk(sp, 0);
    $display("test stroke done");
    end_of_test();
  end
endmodule : ascm_speed_ctrl_tb_top
`default_nettype wire
